// ### osa_defs.svh
`ifndef OSA_DEFS_SVH
`define OSA_DEFS_SVH
// ==========================================================
// Specifier byte fields
`define OSA_MODE_MSB 7
`define OSA_MODE_LSB 4
`define OSA_REG_MSB 3
`define OSA_REG_LSB 0
// ==========================================================
// Mode field codes
`define OSA_MODE_REG 4'h5
`define OSA_MODE_DEFER 4'h6
`define OSA_MODE_ADEC 4'h7
`define OSA_MODE_AINC 4'h8
`define OSA_MODE_AIDF 4'h9
`define OSA_MODE_DISPB 4'hA
`define OSA_MODE_DISPW 4'hC
`define OSA_MODE_DISPL 4'hE
// ==========================================================
// Special register numbers
`define OSA_PC_SEL 4'hF
`define OSA_SP_SEL 4'hE
`define OSA_R13_SEL 4'hD
`define OSA_R12_SEL 4'hC
// ==========================================================
// Sizes in bytes
`define OSA_SZ_BYTE 5'h01
`define OSA_SZ_WORD 5'h02
`define OSA_SZ_LONG 5'h04
`define OSA_SZ_QUAD 5'h08
`define OSA_SZ_OCTA 5'h10
// ==========================================================
// Register counts for register mode
`define OSA_CNT_ONE 3'h1
`define OSA_CNT_TWO 3'h2
`define OSA_CNT_FOUR 3'h4
// ==========================================================
// Undefined-register masks for bad multi-register writes
`define OSA_CLOB_NONE 16'h0000
`define OSA_CLOB_PC2 16'h0001
`define OSA_CLOB_PC4 16'h0007
`define OSA_CLOB_R13_4 16'h0001
`define OSA_CLOB_SP4 16'h0003
// ==========================================================
// Reset values
`define OSA_WORD_RESET 32'h00000000
`define OSA_BYTE_RESET 8'h00
`endif

// ### osa_pkg.sv
package osa_pkg;
	// ==========================================================
	// Operand access types
	typedef enum logic [2:0] {
		OSA_ACC_READ = 3'b000,
		OSA_ACC_WRITE = 3'b001,
		OSA_ACC_MODIFY = 3'b010,
		OSA_ACC_ADDR = 3'b011,
		OSA_ACC_FIELD = 3'b100
	} osa_access_t;
	// ==========================================================
	// Operand data types
	typedef enum logic [3:0] {
		OSA_DT_BYTE = 4'b0000,
		OSA_DT_WORD = 4'b0001,
		OSA_DT_LONG = 4'b0010,
		OSA_DT_FFLT = 4'b0011,
		OSA_DT_QUAD = 4'b0100,
		OSA_DT_DFLT = 4'b0101,
		OSA_DT_GFLT = 4'b0110,
		OSA_DT_OCTA = 4'b0111,
		OSA_DT_HFLT = 4'b1000
	} osa_dtype_t;
	// ==========================================================
	// Decoder states
	typedef enum logic [2:0] {
		OSA_ST_IDLE = 3'b000,
		OSA_ST_SPEC = 3'b001,
		OSA_ST_EXT = 3'b010,
		OSA_ST_REG = 3'b011,
		OSA_ST_MEM = 3'b100,
		OSA_ST_DONE = 3'b101
	} osa_state_t;
endpackage

// ### osa_if.sv
`timescale 1ns/1ps
interface osa_if
	import osa_pkg::*;
();
	// Operand request
	logic op_valid;
	logic op_ready;
	osa_access_t op_access;
	osa_dtype_t op_dtype;
	// Instruction stream bytes
	logic ib_req;
	logic ib_valid;
	logic [7:0] ib_byte;
	// Register file
	logic rf_rd_req;
	logic [3:0] rf_rd_sel;
	logic rf_rd_valid;
	logic [31:0] rf_rd_data;
	logic rf_wr_en;
	logic [3:0] rf_wr_sel;
	logic [31:0] rf_wr_data;
	// Memory longword read
	logic mem_rd_req;
	logic [31:0] mem_addr;
	logic mem_rd_valid;
	logic [31:0] mem_rd_data;

	modport dev (
		input op_valid, op_access, op_dtype, ib_valid, ib_byte,
		input rf_rd_valid, rf_rd_data, mem_rd_valid, mem_rd_data,
		output op_ready, ib_req, rf_rd_req, rf_rd_sel,
		output rf_wr_en, rf_wr_sel, rf_wr_data, mem_rd_req, mem_addr
	);
	modport host (
		output op_valid, op_access, op_dtype, ib_valid, ib_byte,
		output rf_rd_valid, rf_rd_data, mem_rd_valid, mem_rd_data,
		input op_ready, ib_req, rf_rd_req, rf_rd_sel,
		input rf_wr_en, rf_wr_sel, rf_wr_data, mem_rd_req, mem_addr
	);
endinterface

// ### osa_size_sign_extend.sv
`timescale 1ns/1ps
`include "osa_defs.svh"
module osa_size_sign_extend
	import osa_pkg::*;
(
	input wire osa_dtype_t dtype_in, // Operand data type
	input wire logic [31:0] disp_raw_in, // Bytes, newest in top lane
	input wire logic [4:0] disp_bytes_in, // Displacement length
	output logic [4:0] size_out, // Operand size in bytes
	output logic [31:0] sign_extend_out // Justified displacement
);
	// ==========================================================
	// Size per data type
	always_comb begin
		case (dtype_in)
			OSA_DT_BYTE: size_out = `OSA_SZ_BYTE;
			OSA_DT_WORD: size_out = `OSA_SZ_WORD;
			OSA_DT_LONG, OSA_DT_FFLT: size_out = `OSA_SZ_LONG;
			OSA_DT_QUAD, OSA_DT_DFLT, OSA_DT_GFLT: size_out = `OSA_SZ_QUAD;
			OSA_DT_OCTA, OSA_DT_HFLT: size_out = `OSA_SZ_OCTA;
			default: size_out = `OSA_SZ_LONG;
		endcase
	end

	// ==========================================================
	// Right-justify and sign extend the collected bytes
	always_comb begin
		case (disp_bytes_in)
			`OSA_SZ_BYTE: sign_extend_out =
				{{24{disp_raw_in[31]}}, disp_raw_in[31:24]};
			`OSA_SZ_WORD: sign_extend_out =
				{{16{disp_raw_in[31]}}, disp_raw_in[31:16]};
			default: sign_extend_out = disp_raw_in;
		endcase
	end
endmodule

// ### osa_decoder.sv
`timescale 1ns/1ps
`include "osa_defs.svh"
module osa_decoder
	import osa_pkg::*;
(
	input wire logic clk_in, // Processor clock
	input wire logic rst_n_in, // Async reset, active low
	osa_if.dev bus, // Stream, register file and memory
	output logic res_valid_out, // Result strobe
	output logic res_is_reg_out, // Operand lives in registers
	output logic [3:0] res_reg_sel_out, // Base register of operand
	output logic [2:0] res_reg_cnt_out, // Registers joined
	output logic [31:0] operand_address_out, // Operand address
	output logic res_imm_out, // Operand is immediate data
	output logic res_fault_out, // Illegal addressing mode
	output logic res_unpred_out, // Result undefined
	output logic [15:0] res_clobber_out // Registers left undefined
);
	osa_state_t state;
	osa_access_t access_q;
	osa_dtype_t dtype_q;
	logic [3:0] mode_q;
	logic [3:0] base_register_sel;
	logic [4:0] ext_left;
	logic [4:0] ext_len;
	logic after_ext_reg;
	logic [31:0] ext_data;
	logic [31:0] addr_q;
	logic [4:0] size;
	logic [31:0] sign_extend;
	logic [3:0] spec_mode;
	logic [3:0] spec_reg;
	logic is_pc;
	logic wr_access;
	logic [2:0] reg_cnt;

	// ==========================================================
	// Field split and size lookup
	assign spec_mode = bus.ib_byte[`OSA_MODE_MSB:`OSA_MODE_LSB];
	assign spec_reg = bus.ib_byte[`OSA_REG_MSB:`OSA_REG_LSB];
	assign is_pc = (base_register_sel == `OSA_PC_SEL);
	assign wr_access = (access_q == OSA_ACC_WRITE) ||
		(access_q == OSA_ACC_MODIFY);

	osa_size_sign_extend u_size (
		.dtype_in(dtype_q),
		.disp_raw_in(ext_data),
		.disp_bytes_in(ext_len),
		.size_out(size),
		.sign_extend_out(sign_extend)
	);

	// Registers joined in register mode
	always_comb begin
		case (dtype_q)
			OSA_DT_OCTA, OSA_DT_HFLT: reg_cnt = `OSA_CNT_FOUR;
			OSA_DT_QUAD, OSA_DT_DFLT, OSA_DT_GFLT: reg_cnt = `OSA_CNT_TWO;
			default: reg_cnt = (access_q == OSA_ACC_FIELD) ?
				`OSA_CNT_TWO : `OSA_CNT_ONE;
		endcase
	end

	// ==========================================================
	// Sequencer: specifier, extensions, register, memory
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= OSA_ST_IDLE;
			bus.op_ready <= 1'b0;
			bus.ib_req <= 1'b0;
			bus.rf_rd_req <= 1'b0;
			bus.rf_rd_sel <= 4'h0;
			access_q <= OSA_ACC_READ;
			dtype_q <= OSA_DT_BYTE;
			mode_q <= 4'h0;
			base_register_sel <= 4'h0;
			ext_left <= 5'h00;
			ext_len <= 5'h00;
			after_ext_reg <= 1'b0;
		end else begin
			bus.ib_req <= 1'b0;
			bus.rf_rd_req <= 1'b0;
			case (state)
				OSA_ST_IDLE: begin
					bus.op_ready <= 1'b1;
					if (bus.op_valid && bus.op_ready) begin
						bus.op_ready <= 1'b0;
						access_q <= bus.op_access;
						dtype_q <= bus.op_dtype;
						bus.ib_req <= 1'b1;
						state <= OSA_ST_SPEC;
					end
				end
				OSA_ST_SPEC: if (bus.ib_valid) begin
					mode_q <= spec_mode;
					base_register_sel <= spec_reg;
					bus.rf_rd_sel <= spec_reg;
					after_ext_reg <= 1'b1;
					case (spec_mode)
						`OSA_MODE_REG: state <= OSA_ST_DONE;
						`OSA_MODE_DEFER, `OSA_MODE_ADEC, `OSA_MODE_AINC: begin
							bus.rf_rd_req <= 1'b1;
							state <= OSA_ST_REG;
						end
						`OSA_MODE_AIDF: begin
							if (spec_reg == `OSA_PC_SEL) begin
								ext_left <= `OSA_SZ_LONG;
								ext_len <= `OSA_SZ_LONG;
								after_ext_reg <= 1'b0;
								bus.ib_req <= 1'b1;
								state <= OSA_ST_EXT;
							end else begin
								bus.rf_rd_req <= 1'b1;
								state <= OSA_ST_REG;
							end
						end
						`OSA_MODE_DISPB, `OSA_MODE_DISPW, `OSA_MODE_DISPL: begin
							ext_left <= (spec_mode == `OSA_MODE_DISPB) ?
								`OSA_SZ_BYTE : (spec_mode == `OSA_MODE_DISPW) ?
								`OSA_SZ_WORD : `OSA_SZ_LONG;
							ext_len <= (spec_mode == `OSA_MODE_DISPB) ?
								`OSA_SZ_BYTE : (spec_mode == `OSA_MODE_DISPW) ?
								`OSA_SZ_WORD : `OSA_SZ_LONG;
							bus.ib_req <= 1'b1;
							state <= OSA_ST_EXT;
						end
						default: state <= OSA_ST_DONE;
					endcase
				end
				OSA_ST_EXT: if (bus.ib_valid) begin
					if (ext_left == 5'h01) begin
						// Base read only after the last byte
						bus.rf_rd_req <= after_ext_reg;
						state <= after_ext_reg ? OSA_ST_REG : OSA_ST_DONE;
					end else begin
						ext_left <= ext_left - 5'h01;
						bus.ib_req <= 1'b1;
					end
				end
				OSA_ST_REG: if (bus.rf_rd_valid) begin
					if (mode_q == `OSA_MODE_AIDF) begin
						state <= OSA_ST_MEM;
					end else if (mode_q == `OSA_MODE_AINC && is_pc) begin
						// Skip over immediate data in the stream
						ext_left <= size;
						ext_len <= `OSA_SZ_LONG;
						after_ext_reg <= 1'b0;
						bus.ib_req <= 1'b1;
						state <= OSA_ST_EXT;
					end else begin
						state <= OSA_ST_DONE;
					end
				end
				OSA_ST_MEM: if (bus.mem_rd_valid) state <= OSA_ST_DONE;
				OSA_ST_DONE: state <= OSA_ST_IDLE;
				default: state <= OSA_ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Extension byte collection, newest byte in top lane
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ext_data <= `OSA_WORD_RESET;
		end else if (state == OSA_ST_SPEC) begin
			ext_data <= `OSA_WORD_RESET;
		end else if (state == OSA_ST_EXT && bus.ib_valid) begin
			ext_data <= {bus.ib_byte, ext_data[31:8]};
		end
	end

	// ==========================================================
	// Address forming and base register update
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			addr_q <= `OSA_WORD_RESET;
			bus.rf_wr_en <= 1'b0;
			bus.rf_wr_sel <= 4'h0;
			bus.rf_wr_data <= `OSA_WORD_RESET;
			bus.mem_rd_req <= 1'b0;
			bus.mem_addr <= `OSA_WORD_RESET;
		end else begin
			bus.rf_wr_en <= 1'b0;
			bus.mem_rd_req <= 1'b0;
			bus.rf_wr_sel <= base_register_sel;
			if (state == OSA_ST_REG && bus.rf_rd_valid) begin
				case (mode_q)
					`OSA_MODE_DEFER: addr_q <= bus.rf_rd_data;
					`OSA_MODE_ADEC: begin
						addr_q <= bus.rf_rd_data - {27'h0, size};
						bus.rf_wr_en <= !is_pc;
						bus.rf_wr_data <= bus.rf_rd_data - {27'h0, size};
					end
					`OSA_MODE_AINC: begin
						addr_q <= bus.rf_rd_data;
						bus.rf_wr_en <= !is_pc;
						bus.rf_wr_data <= bus.rf_rd_data + {27'h0, size};
					end
					`OSA_MODE_AIDF: begin
						bus.mem_rd_req <= 1'b1;
						bus.mem_addr <= bus.rf_rd_data;
						bus.rf_wr_en <= 1'b1;
						bus.rf_wr_data <= bus.rf_rd_data +
							{27'h0, `OSA_SZ_LONG};
					end
					default: addr_q <= bus.rf_rd_data + sign_extend;
				endcase
			end else if (state == OSA_ST_MEM && bus.mem_rd_valid) begin
				addr_q <= bus.mem_rd_data;
			end else if (state == OSA_ST_EXT && bus.ib_valid &&
				ext_left == 5'h01 && mode_q == `OSA_MODE_AIDF) begin
				addr_q <= {bus.ib_byte, ext_data[31:8]};
			end
		end
	end

	// ==========================================================
	// Result, fault and undefined-case reporting
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			res_valid_out <= 1'b0;
			res_is_reg_out <= 1'b0;
			res_reg_sel_out <= 4'h0;
			res_reg_cnt_out <= 3'h0;
			operand_address_out <= `OSA_WORD_RESET;
			res_imm_out <= 1'b0;
			res_fault_out <= 1'b0;
			res_unpred_out <= 1'b0;
			res_clobber_out <= `OSA_CLOB_NONE;
		end else begin
			res_valid_out <= (state == OSA_ST_DONE);
			if (state == OSA_ST_DONE) begin
				res_is_reg_out <= (mode_q == `OSA_MODE_REG);
				res_reg_sel_out <= base_register_sel;
				res_reg_cnt_out <= (mode_q == `OSA_MODE_REG) ?
					reg_cnt : 3'h0;
				operand_address_out <= addr_q;
				res_imm_out <= (mode_q == `OSA_MODE_AINC) && is_pc;
				res_fault_out <= ((mode_q == `OSA_MODE_REG) &&
					(access_q == OSA_ACC_ADDR)) ||
					!((mode_q >= `OSA_MODE_REG && mode_q <= `OSA_MODE_DISPB)
					|| mode_q == `OSA_MODE_DISPW ||
					mode_q == `OSA_MODE_DISPL);
				res_unpred_out <= ((mode_q == `OSA_MODE_REG) && (is_pc ||
					(reg_cnt != `OSA_CNT_ONE &&
					base_register_sel == `OSA_SP_SEL) ||
					(reg_cnt == `OSA_CNT_FOUR &&
					base_register_sel >= `OSA_R12_SEL))) ||
					(mode_q == `OSA_MODE_DEFER && is_pc) ||
					(mode_q == `OSA_MODE_ADEC && is_pc) ||
					(mode_q == `OSA_MODE_AINC && is_pc && wr_access);
				res_clobber_out <= `OSA_CLOB_NONE;
				if (mode_q == `OSA_MODE_REG && wr_access) begin
					if (reg_cnt == `OSA_CNT_TWO && is_pc)
						res_clobber_out <= `OSA_CLOB_PC2;
					else if (reg_cnt == `OSA_CNT_FOUR && is_pc)
						res_clobber_out <= `OSA_CLOB_PC4;
					else if (reg_cnt == `OSA_CNT_FOUR &&
						base_register_sel == `OSA_R13_SEL)
						res_clobber_out <= `OSA_CLOB_R13_4;
					else if (reg_cnt == `OSA_CNT_FOUR &&
						base_register_sel == `OSA_SP_SEL)
						res_clobber_out <= `OSA_CLOB_SP4;
				end
			end
		end
	end
endmodule

// ### osa_host.sv
`timescale 1ns/1ps
`include "osa_defs.svh"
module osa_host
	import osa_pkg::*;
#(
	parameter int IB_AW = 6, // Stream memory address width
	parameter int DM_AW = 4 // Data memory address width (longwords)
) (
	input wire logic clk_in, // Processor clock
	input wire logic rst_n_in, // Async reset, active low
	osa_if.host bus, // Decoder side
	input wire logic req_in, // Request one operand, pulse
	input wire osa_access_t access_in, // Access type of request
	input wire osa_dtype_t dtype_in, // Data type of request
	input wire logic rf_load_en_in, // Preload a register
	input wire logic [3:0] rf_load_sel_in, // Register to preload
	input wire logic [31:0] rf_load_data_in, // Preload value
	input wire logic ib_load_en_in, // Write a stream byte
	input wire logic [IB_AW-1:0] ib_load_addr_in, // Stream byte index
	input wire logic [7:0] ib_load_byte_in, // Stream byte value
	input wire logic dm_load_en_in, // Write a data longword
	input wire logic [DM_AW-1:0] dm_load_addr_in, // Longword index
	input wire logic [31:0] dm_load_data_in, // Longword value
	output logic [31:0] pc_out, // Current stream pointer
	output logic busy_out // Request pending
);
	logic [31:0] regs [0:15];
	logic [7:0] stream [0:(1<<IB_AW)-1];
	logic [31:0] dmem [0:(1<<DM_AW)-1];

	assign pc_out = regs[`OSA_PC_SEL];
	assign busy_out = bus.op_valid;

	// ==========================================================
	// Register file, PC advances on each stream byte
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < 16; i++) begin
				regs[i] <= `OSA_WORD_RESET;
			end
		end else if (rf_load_en_in) begin
			regs[rf_load_sel_in] <= rf_load_data_in;
		end else begin
			if (bus.rf_wr_en)
				regs[bus.rf_wr_sel] <= bus.rf_wr_data;
			if (bus.ib_req)
				regs[`OSA_PC_SEL] <= regs[`OSA_PC_SEL] + 32'h00000001;
		end
	end

	// Memory images
	always_ff @(posedge clk_in) begin
		if (ib_load_en_in)
			stream[ib_load_addr_in] <= ib_load_byte_in;
		if (dm_load_en_in)
			dmem[dm_load_addr_in] <= dm_load_data_in;
	end

	// ==========================================================
	// One-cycle answers to stream, register and memory reads
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bus.ib_valid <= 1'b0;
			bus.ib_byte <= `OSA_BYTE_RESET;
			bus.rf_rd_valid <= 1'b0;
			bus.rf_rd_data <= `OSA_WORD_RESET;
			bus.mem_rd_valid <= 1'b0;
			bus.mem_rd_data <= `OSA_WORD_RESET;
		end else begin
			bus.ib_valid <= bus.ib_req;
			if (bus.ib_req)
				bus.ib_byte <= stream[regs[`OSA_PC_SEL][IB_AW-1:0]];
			bus.rf_rd_valid <= bus.rf_rd_req;
			if (bus.rf_rd_req)
				bus.rf_rd_data <= regs[bus.rf_rd_sel];
			bus.mem_rd_valid <= bus.mem_rd_req;
			if (bus.mem_rd_req)
				bus.mem_rd_data <= dmem[bus.mem_addr[DM_AW+1:2]];
		end
	end

	// ==========================================================
	// Operand request hold until taken
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bus.op_valid <= 1'b0;
			bus.op_access <= OSA_ACC_READ;
			bus.op_dtype <= OSA_DT_BYTE;
		end else if (bus.op_valid && bus.op_ready) begin
			bus.op_valid <= 1'b0;
		end else if (req_in && !bus.op_valid) begin
			bus.op_valid <= 1'b1;
			bus.op_access <= access_in;
			bus.op_dtype <= dtype_in;
		end
	end
endmodule

// ### osa_checker_props.sv
`timescale 1ns/1ps
module osa_checker
	import osa_pkg::*;
(
	input wire logic clk_in, // Processor clock
	input wire logic rst_n_in, // Async reset, active low
	input wire logic op_valid, // Operand request
	input wire logic op_ready, // Decoder ready
	input wire osa_dtype_t op_dtype, // Operand data type
	input wire logic ib_req, // Stream byte request
	input wire logic ib_valid, // Stream byte answer
	input wire logic rf_rd_req, // Register read request
	input wire logic [3:0] rf_rd_sel, // Register read select
	input wire logic rf_rd_valid, // Register read answer
	input wire logic [31:0] rf_rd_data, // Register read data
	input wire logic rf_wr_en, // Register write strobe
	input wire logic [3:0] rf_wr_sel, // Register write select
	input wire logic [31:0] rf_wr_data, // Register write data
	input wire logic mem_rd_req, // Longword read request
	input wire logic [31:0] mem_addr, // Longword address
	input wire logic mem_rd_valid // Longword read answer
);
	// ==========================================================
	// Operand size in bytes for the step checks
	function automatic logic [31:0] op_size(osa_dtype_t d);
		case (d)
			OSA_DT_BYTE: op_size = 32'h00000001;
			OSA_DT_WORD: op_size = 32'h00000002;
			OSA_DT_LONG, OSA_DT_FFLT: op_size = 32'h00000004;
			OSA_DT_OCTA, OSA_DT_HFLT: op_size = 32'h00000010;
			default: op_size = 32'h00000008;
		endcase
	endfunction
	// ==========================================================
	// Handshake steps
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence take_s;
		op_valid && op_ready;
	endsequence
	sequence fetch_s;
		ib_req ##1 ib_valid;
	endsequence
	// ==========================================================
	// Properties
	AST_FIRST_BYTE:
	assert property (take_s |=> fetch_s)
		else $error("no specifier fetch after take");
	AST_READY_DROP:
	assert property (take_s |=> !op_ready)
		else $error("ready held after take");
	AST_READY_BACK:
	assert property ($fell(op_ready) |-> ##[1:80] op_ready)
		else $error("operand never finished");
	AST_IB_ANSWER:
	assert property (ib_req |=> ib_valid)
		else $error("stream byte not answered");
	AST_IB_SPACING:
	assert property (ib_req |=> !ib_req)
		else $error("stream requests back to back");
	AST_RF_ANSWER:
	assert property (rf_rd_req |=> rf_rd_valid)
		else $error("register read not answered");
	AST_MEM_ANSWER:
	assert property (mem_rd_req |=> mem_rd_valid)
		else $error("longword read not answered");
	AST_AIDF_STEP:
	assert property (mem_rd_req |-> rf_wr_en && rf_wr_data == mem_addr + 32'h4)
		else $error("deferred base not stepped by four");
	AST_STEP:
	assert property (rf_wr_en && !mem_rd_req |->
		rf_wr_data == $past(rf_rd_data) + op_size(op_dtype) ||
		rf_wr_data == $past(rf_rd_data) - op_size(op_dtype))
		else $error("base step not operand size");
	AST_WR_SEL:
	assert property (rf_wr_en |->
		$past(rf_rd_valid) && rf_wr_sel == $past(rf_rd_sel, 2))
		else $error("write back to wrong register");
	AST_NO_PC_WRITE:
	assert property (rf_wr_en |-> rf_wr_sel != 4'hF)
		else $error("stream pointer written by decoder");
endmodule

// ### operand_specifier_address_calc_test.sv
`timescale 1ns/1ps
`include "osa_defs.svh"
`define CHK(nm, ex, got) begin \
	cmp_count++; \
	if ((got) !== (ex)) begin \
		err_total++; \
		$display("wrong value %s exp %0h got %0h", nm, ex, got); \
	end \
end
module operand_specifier_address_calc_test;
	import osa_pkg::*;
	logic clk_in, rst_n_in, req_in, rf_load_en_in, ib_load_en_in;
	logic dm_load_en_in, busy_out, res_valid_out, res_is_reg_out;
	logic res_imm_out, res_fault_out, res_unpred_out;
	osa_access_t access_in;
	osa_dtype_t dtype_in;
	logic [2:0] res_reg_cnt_out;
	logic [3:0] rf_load_sel_in, dm_load_addr_in, res_reg_sel_out, wr_sel;
	logic [5:0] ib_load_addr_in, ptr;
	logic [7:0] ib_load_byte_in;
	logic [15:0] res_clobber_out;
	logic [31:0] rf_load_data_in, dm_load_data_in, pc_out, wr_data;
	logic [31:0] operand_address_out;
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	int wr_cnt = 0;
	osa_if ifc();
	osa_decoder osa_decoder_i(.clk_in(clk_in), .rst_n_in(rst_n_in),
		.bus(ifc), .res_valid_out(res_valid_out),
		.res_is_reg_out(res_is_reg_out), .res_reg_sel_out(res_reg_sel_out),
		.res_reg_cnt_out(res_reg_cnt_out), .res_imm_out(res_imm_out),
		.operand_address_out(operand_address_out),
		.res_fault_out(res_fault_out), .res_unpred_out(res_unpred_out),
		.res_clobber_out(res_clobber_out));
	osa_host #(.IB_AW(6), .DM_AW(4)) osa_host_i(.clk_in(clk_in),
		.rst_n_in(rst_n_in), .bus(ifc), .req_in(req_in),
		.access_in(access_in), .dtype_in(dtype_in),
		.rf_load_en_in(rf_load_en_in), .rf_load_sel_in(rf_load_sel_in),
		.rf_load_data_in(rf_load_data_in), .ib_load_en_in(ib_load_en_in),
		.ib_load_addr_in(ib_load_addr_in), .ib_load_byte_in(ib_load_byte_in),
		.dm_load_en_in(dm_load_en_in), .dm_load_addr_in(dm_load_addr_in),
		.dm_load_data_in(dm_load_data_in), .pc_out(pc_out),
		.busy_out(busy_out));
	osa_checker osa_checker_i(.clk_in(clk_in), .rst_n_in(rst_n_in),
		.op_valid(ifc.op_valid), .op_ready(ifc.op_ready),
		.op_dtype(ifc.op_dtype), .ib_req(ifc.ib_req),
		.ib_valid(ifc.ib_valid), .rf_rd_req(ifc.rf_rd_req),
		.rf_rd_sel(ifc.rf_rd_sel), .rf_rd_valid(ifc.rf_rd_valid),
		.rf_rd_data(ifc.rf_rd_data), .rf_wr_en(ifc.rf_wr_en),
		.rf_wr_sel(ifc.rf_wr_sel), .rf_wr_data(ifc.rf_wr_data),
		.mem_rd_req(ifc.mem_rd_req), .mem_addr(ifc.mem_addr),
		.mem_rd_valid(ifc.mem_rd_valid));
	// ==========================================================
	// Clock, hang guard and write-back capture
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cyc++;
		if (cyc >= 5000) begin
			err_total++;
			close_out();
		end
	end
	always @(posedge clk_in) begin
		if (ifc.rf_wr_en === 1'b1) begin
			wr_sel = ifc.rf_wr_sel;
			wr_data = ifc.rf_wr_data;
			wr_cnt++;
		end
	end
	// ==========================================================
	// Loading and request tasks
	task automatic put(input logic [7:0] b);
		@(posedge clk_in);
		ib_load_en_in <= 1'b1;
		ib_load_addr_in <= ptr;
		ib_load_byte_in <= b;
		ptr = ptr + 6'h01;
		@(posedge clk_in);
		ib_load_en_in <= 1'b0;
	endtask
	task automatic set_reg(input logic [3:0] s, input logic [31:0] d);
		@(posedge clk_in);
		rf_load_en_in <= 1'b1;
		rf_load_sel_in <= s;
		rf_load_data_in <= d;
		@(posedge clk_in);
		rf_load_en_in <= 1'b0;
	endtask
	task automatic go(input osa_access_t a, input osa_dtype_t d);
		int n;
		wr_cnt = 0;
		n = 0;
		@(posedge clk_in);
		req_in <= 1'b1;
		access_in <= a;
		dtype_in <= d;
		@(posedge clk_in);
		req_in <= 1'b0;
		while (res_valid_out !== 1'b1 && n < 200) begin
			@(negedge clk_in);
			n++;
		end
		while (busy_out !== 1'b0 && n < 200) begin
			@(negedge clk_in);
			n++;
		end
		`CHK("finished", 1'b1, n < 200)
		`CHK("stream pointer", {26'h0, ptr}, pc_out)
	endtask
	// ==========================================================
	// Scenarios
	task automatic reg_case(input logic [7:0] s, input osa_access_t a,
		input osa_dtype_t d, input logic [2:0] cnt, input logic flt,
		input logic up, input logic [15:0] clob);
		put(s);
		go(a, d);
		`CHK("is_reg", 1'b1, res_is_reg_out)
		`CHK("reg_sel", s[3:0], res_reg_sel_out)
		`CHK("reg_cnt", cnt, res_reg_cnt_out)
		`CHK("fault", flt, res_fault_out)
		`CHK("unpred", up, res_unpred_out)
		`CHK("clobber", clob, res_clobber_out)
		`CHK("writes", 0, wr_cnt)
	endtask
	task automatic t_register();
		// Plain register cases keep the stream pointer out of register mode; the undefined cases use R13, SP and PC
		reg_case(8'h53, OSA_ACC_READ, OSA_DT_LONG, 3'h1, 1'b0, 1'b0, 16'h0);
		reg_case(8'h54, OSA_ACC_READ, OSA_DT_DFLT, 3'h2, 1'b0, 1'b0, 16'h0);
		reg_case(8'h52, OSA_ACC_FIELD, OSA_DT_LONG, 3'h2, 1'b0, 1'b0, 16'h0);
		reg_case(8'h55, OSA_ACC_ADDR, OSA_DT_LONG, 3'h1, 1'b1, 1'b0, 16'h0);
		reg_case(8'h5D, OSA_ACC_WRITE, OSA_DT_OCTA, 3'h4, 1'b0, 1'b1, 16'h1);
		reg_case(8'h5E, OSA_ACC_WRITE, OSA_DT_HFLT, 3'h4, 1'b0, 1'b1, 16'h3);
		reg_case(8'h5F, OSA_ACC_MODIFY, OSA_DT_OCTA, 3'h4, 1'b0, 1'b1, 16'h7);
		reg_case(8'h5F, OSA_ACC_WRITE, OSA_DT_QUAD, 3'h2, 1'b0, 1'b1, 16'h1);
		$display("test register mode done");
	endtask
	task automatic t_autoinc();
		logic [31:0] cur;
		logic [4:0] sz [9] = '{`OSA_SZ_BYTE, `OSA_SZ_WORD, `OSA_SZ_LONG,
			`OSA_SZ_LONG, `OSA_SZ_QUAD, `OSA_SZ_QUAD, `OSA_SZ_QUAD,
			`OSA_SZ_OCTA, `OSA_SZ_OCTA};
		cur = 32'h00000100;
		set_reg(4'h5, cur);
		for (int i = 0; i < 9; i++) begin
			put(8'h85);
			go(OSA_ACC_READ, osa_dtype_t'(i));
			`CHK("ainc addr", cur, operand_address_out)
			cur = cur + {27'h0, sz[i]};
			`CHK("ainc base", cur, wr_data)
			`CHK("ainc sel", 4'h5, wr_sel)
		end
		$display("test autoincrement done");
	endtask
	task automatic t_memory_modes();
		set_reg(4'h4, 32'h00001234);
		put(8'h64);
		go(OSA_ACC_READ, OSA_DT_LONG);
		`CHK("defer addr", 32'h00001234, operand_address_out)
		`CHK("defer writes", 0, wr_cnt)
		set_reg(4'h6, 32'h00000200);
		put(8'h76);
		go(OSA_ACC_MODIFY, OSA_DT_OCTA);
		`CHK("adec addr", 32'h000001F0, operand_address_out)
		`CHK("adec base", 32'h000001F0, wr_data)
		set_reg(4'h7, 32'h00000020);
		@(posedge clk_in);
		dm_load_en_in <= 1'b1;
		dm_load_addr_in <= 4'h8;
		dm_load_data_in <= 32'h0000ABCD;
		@(posedge clk_in);
		dm_load_en_in <= 1'b0;
		put(8'h97);
		go(OSA_ACC_READ, OSA_DT_LONG);
		`CHK("aidf addr", 32'h0000ABCD, operand_address_out)
		`CHK("aidf base", 32'h00000024, wr_data)
		`CHK("aidf sel", 4'h7, wr_sel)
		$display("test memory modes done");
	endtask
	task automatic t_stream_modes();
		logic [31:0] ex;
		put(8'h9F);
		put(8'h78);
		put(8'h56);
		put(8'h34);
		put(8'h12);
		go(OSA_ACC_READ, OSA_DT_LONG);
		`CHK("absolute", 32'h12345678, operand_address_out)
		put(8'h8F);
		ex = {26'h0, ptr};
		repeat (8) put(8'h5A);
		go(OSA_ACC_READ, OSA_DT_QUAD);
		`CHK("imm flag", 1'b1, res_imm_out)
		`CHK("imm addr", ex, operand_address_out)
		`CHK("imm writes", 0, wr_cnt)
		set_reg(4'h2, 32'h00001000);
		put(8'hA2);
		put(8'h80);
		go(OSA_ACC_READ, OSA_DT_LONG);
		`CHK("disp byte", 32'h00000F80, operand_address_out)
		put(8'hCF);
		put(8'hF0);
		put(8'hFF);
		go(OSA_ACC_READ, OSA_DT_LONG);
		ex = {26'h0, ptr} - 32'h10;
		`CHK("pc relative", ex, operand_address_out)
		put(8'hE2);
		put(8'h00);
		put(8'h00);
		put(8'h01);
		put(8'h00);
		go(OSA_ACC_READ, OSA_DT_LONG);
		`CHK("disp long", 32'h00011000, operand_address_out)
		put(8'hB2);
		go(OSA_ACC_READ, OSA_DT_LONG);
		`CHK("bad mode", 1'b1, res_fault_out)
		$display("test stream modes done");
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		rst_n_in = 1'b0;
		req_in = 1'b0;
		access_in = OSA_ACC_READ;
		dtype_in = OSA_DT_LONG;
		{rf_load_en_in, ib_load_en_in, dm_load_en_in} = 3'h0;
		{rf_load_sel_in, dm_load_addr_in, ib_load_addr_in} = 14'h0;
		{rf_load_data_in, dm_load_data_in, ib_load_byte_in} = 72'h0;
		ptr = 6'h00;
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'b1;
		t_register();
		t_autoinc();
		t_memory_modes();
		t_stream_modes();
		close_out();
	end
endmodule
